// >>> rtl/lsf_status.sv
// link status register block with APB slave and interrupt
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lsf_status
  import lsf_pkg::*;
#(
  parameter longint IDLE_CYC = LSF_IDLE_CYC,
  parameter int IDLE_CW = 28
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lsf_evt_t evt,
  output logic [7:0] link_status_out,
  output logic xfer_stop_out,
  output logic irq
);
  // ==========================================================
  // apb decode
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction

  wire logic acc = psel && penable && ce;
  wire logic sel_st = hit(paddr, LSF_IDX_STATUS);
  wire logic sel_ct = hit(paddr, LSF_IDX_CONTROL);
  wire logic sel_is = hit(paddr, LSF_IDX_IRQ_STAT);
  wire logic sel_im = hit(paddr, LSF_IDX_IRQ_MASK);
  wire logic mapped = sel_st || sel_ct || sel_is || sel_im;
  wire logic wr = acc && pwrite && pready;
  wire logic rd = acc && !pwrite && !pready;
  wire logic wr_ct = wr && sel_ct;
  wire logic wr_im = wr && sel_im;
  wire logic rd_is = rd && sel_is;

  // ==========================================================
  // control register; clear bits self-clear
  logic [7:0] ctrl_ff;
  wire logic [7:0] wdat = pwdata[7:0];
  wire logic irq_clear_cmd = wr_ct && wdat[LSF_C_IRQCLR];
  wire logic error_clear_cmd = wr_ct && wdat[LSF_C_ERRCLR];
  wire logic stop_cmd = wr_ct && wdat[LSF_C_STOP];
  wire logic slave = ctrl_ff[LSF_C_SLAVE];
  wire logic [7:0] nxt_ctrl = wr_ct ?
    (wdat & ~(8'h01 << LSF_C_IRQCLR) & ~(8'h01 << LSF_C_ERRCLR) &
     ~(8'h01 << LSF_C_STOP)) : ctrl_ff;

  // ==========================================================
  // idle timer
  logic idle_exp;
  lsf_idle_timer #(
    .CW(IDLE_CW),
    .LIMIT(IDLE_CYC)
  ) u_idle (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .restart(evt.activity || !slave || evt.sleeping),
    .expired(idle_exp)
  );

  // ==========================================================
  // status flags
  logic [7:0] st_ff;
  logic [7:0] nxt_st;
  lsf_xfer_t xs_ff;
  lsf_xfer_t nxt_xs;

  always_comb begin
    nxt_st = st_ff;
    nxt_st[LSF_B_ACTIVE] = evt.activity;
    nxt_st[LSF_B_IDLE] = slave && idle_exp && !evt.sleeping;
    if (!slave) begin
      nxt_st[LSF_B_ABORT] = 1'b0;
      nxt_st[LSF_B_IDRX] = 1'b0;
    end else begin
      if (evt.break_rx && !evt.break_cut) begin
        nxt_st[LSF_B_ABORT] = 1'b0;
      end
      if (stop_cmd) begin
        nxt_st[LSF_B_ABORT] = 1'b1;
      end
      if (evt.xfer_start) begin
        nxt_st[LSF_B_IDRX] = 1'b0;
      end
      if (evt.id_rx) begin
        nxt_st[LSF_B_IDRX] = 1'b1;
      end
    end
    if (irq_clear_cmd) begin
      nxt_st[LSF_B_PEND] = 1'b0;
    end
    if (evt.irq_req) begin
      nxt_st[LSF_B_PEND] = 1'b1;
    end
    if (error_clear_cmd) begin
      nxt_st[LSF_B_ERR] = 1'b0;
    end
    if (evt.err) begin
      nxt_st[LSF_B_ERR] = 1'b1;
    end
    if (evt.wake_tx || evt.wake_rx) begin
      nxt_st[LSF_B_WAKE] = 1'b1;
    end else if (evt.xfer_start) begin
      nxt_st[LSF_B_WAKE] = 1'b0;
    end
    nxt_st[LSF_B_DONE] = (nxt_xs == LSF_X_DONE);
  end

  always_comb begin
    case (xs_ff)
      LSF_X_IDLE: nxt_xs = evt.xfer_start ? LSF_X_BUSY : LSF_X_IDLE;
      LSF_X_BUSY: nxt_xs = evt.xfer_done ? LSF_X_DONE : LSF_X_BUSY;
      LSF_X_DONE: nxt_xs = evt.xfer_start ? LSF_X_BUSY : LSF_X_DONE;
      default: nxt_xs = LSF_X_IDLE;
    endcase
  end

  // ==========================================================
  // interrupt status and mask
  logic [7:0] is_ff;
  logic [7:0] im_ff;
  wire logic [7:0] rise = nxt_st & ~st_ff;
  wire logic [7:0] nxt_is = (rd_is ? 8'h00 : is_ff) | rise;
  wire logic [7:0] nxt_im = wr_im ? wdat : im_ff;

  // ==========================================================
  // read mux
  wire logic [7:0] rmux = sel_st ? st_ff :
    sel_ct ? ctrl_ff : sel_is ? is_ff : sel_im ? im_ff : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= LSF_RST_STATUS;
      xs_ff <= LSF_X_IDLE;
      ctrl_ff <= LSF_RST_CONTROL;
      is_ff <= LSF_RST_STATUS;
      im_ff <= LSF_RST_MASK;
    end else if (ce) begin
      st_ff <= nxt_st;
      xs_ff <= nxt_xs;
      ctrl_ff <= nxt_ctrl;
      is_ff <= nxt_is;
      im_ff <= nxt_im;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      link_status_out <= LSF_RST_STATUS;
      xfer_stop_out <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      pready <= acc && !pready;
      pslverr <= acc && !pready && !mapped;
      prdata <= rd ? {24'h000000, rmux} : 32'h0000_0000;
      link_status_out <= nxt_st;
      xfer_stop_out <= stop_cmd;
      irq <= |(nxt_is & nxt_im);
    end
  end
endmodule
`default_nettype wire

// >>> rtl/lsf_pkg.sv
// package: register map, field positions and timing constants of the status block
package lsf_pkg;

  // ==========================================================
  // register indices (printed offsets are not multiples of four)
  localparam logic [7:0] LSF_IDX_STATUS = 8'h09;
  localparam logic [7:0] LSF_IDX_CONTROL = 8'h08;
  localparam logic [7:0] LSF_IDX_IRQ_STAT = 8'h0A;
  localparam logic [7:0] LSF_IDX_IRQ_MASK = 8'h0B;

  // ==========================================================
  // status field positions
  localparam int LSF_B_ACTIVE = 7;
  localparam int LSF_B_IDLE = 6;
  localparam int LSF_B_ABORT = 5;
  localparam int LSF_B_IDRX = 4;
  localparam int LSF_B_PEND = 3;
  localparam int LSF_B_ERR = 2;
  localparam int LSF_B_WAKE = 1;
  localparam int LSF_B_DONE = 0;

  // ==========================================================
  // control field positions
  localparam int LSF_C_STOP = 7;
  localparam int LSF_C_IRQCLR = 3;
  localparam int LSF_C_ERRCLR = 2;
  localparam int LSF_C_SLAVE = 0;

  // ==========================================================
  // reset values
  localparam logic [7:0] LSF_RST_STATUS = 8'h00;
  localparam logic [7:0] LSF_RST_CONTROL = 8'h00;
  localparam logic [7:0] LSF_RST_MASK = 8'h00;

  // ==========================================================
  // timing
  localparam longint LSF_CLK_HZ = 50000000;
  localparam longint LSF_IDLE_S = 4;
  localparam longint LSF_IDLE_CYC = LSF_IDLE_S * LSF_CLK_HZ;

  // ==========================================================
  // bus events from the link engine
  typedef struct packed {
    logic activity;
    logic sleeping;
    logic break_rx;
    logic break_cut;
    logic id_rx;
    logic irq_req;
    logic err;
    logic wake_tx;
    logic wake_rx;
    logic xfer_start;
    logic xfer_done;
  } lsf_evt_t;

  typedef enum logic [1:0] {
    LSF_X_IDLE = 2'b00,
    LSF_X_BUSY = 2'b01,
    LSF_X_DONE = 2'b10
  } lsf_xfer_t;

endpackage

// >>> rtl/lsf_idle_timer.sv
// idle timer: counts cycles without bus activity
`timescale 1ns/10ps
`default_nettype none
module lsf_idle_timer
  import lsf_pkg::*;
#(
  parameter int CW = 28,
  parameter longint LIMIT = LSF_IDLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic restart,
  output logic expired
);
  // ==========================================================
  // counter
  logic [CW-1:0] cnt_ff;
  wire logic at_lim = (cnt_ff >= CW'(LIMIT - 1));
  wire logic [CW-1:0] nxt_cnt = restart ? '0 :
    (at_lim ? cnt_ff : cnt_ff + CW'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign expired = at_lim && !restart;
endmodule
`default_nettype wire

// >>> dv/lsf_status_sva.sv
// checker: status flag assertions
`timescale 1ns/10ps
`default_nettype none
module lsf_status_sva
  import lsf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire lsf_evt_t evt,
  input wire logic [7:0] link_status_out
);
  // ====================
  // control write decode
  wire logic cw = psel && penable && pwrite &&
    paddr == {2'b00, LSF_IDX_CONTROL, 2'b00};
  wire logic stop_w = cw && pwdata[LSF_C_STOP];
  wire logic eclr_w = cw && pwdata[LSF_C_ERRCLR];
  wire logic iclr_w = cw && pwdata[LSF_C_IRQCLR];
  wire logic [7:0] s = link_status_out;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  act_flag_a: assert property (ce |=> s[7] == $past(evt.activity))
    else $error("activity flag wrong");
  idle_src_a: assert property ($rose(s[6]) |-> !$past(evt.activity))
    else $error("idle flag during activity");
  abort_src_a: assert property ($rose(s[5])
    |-> $past(stop_w) || $past(stop_w, 2)) else $error("abort without stop");
  err_hold_a: assert property ($fell(s[2])
    |-> $past(eclr_w) || $past(eclr_w, 2)) else $error("error flag lost");
  pend_set_a: assert property (ce && evt.irq_req |=> s[3])
    else $error("pending flag not set");
  pend_hold_a: assert property ($fell(s[3])
    |-> $past(iclr_w) || $past(iclr_w, 2)) else $error("pending flag lost");
  err_set_a: assert property (ce && evt.err |=> s[2])
    else $error("error flag not set");
  wake_set_a: assert property (ce && evt.wake_tx |=> s[1])
    else $error("wakeup flag not set");
  done_set_a: assert property (ce && evt.xfer_done |=> s[0])
    else $error("done flag not set");
  cover property (stop_w);
  cover property (eclr_w);
  cover property (s[6]);
  cover property (!ce ##1 ce);
endmodule
`default_nettype wire

// >>> dv/lsf_link_model.sv
// link model: other bus nodes driving event lines
`timescale 1ns/10ps
`default_nettype none
module lsf_link_model
  import lsf_pkg::*;
(
  input wire logic pclk,
  output var lsf_evt_t evt
);
  logic [10:0] base = 11'h000;
  initial evt = lsf_evt_t'(11'h000);
  // ====================
  // levels held, events one cycle
  task hold(input logic [10:0] v);
    @(posedge pclk) evt <= lsf_evt_t'(v);
    base = v;
  endtask
  task pulse(input logic [10:0] v);
    @(posedge pclk) evt <= lsf_evt_t'(v | base);
    @(posedge pclk) evt <= lsf_evt_t'(base);
  endtask
endmodule
`default_nettype wire

// >>> dv/lsf_status_tb_top.sv
// bench: status flags, control clears, interrupt
`timescale 1ns/10ps
`default_nettype none
module lsf_status_tb_top
  import lsf_pkg::*;
  ;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, se, pready, pslverr, xfer_stop_out, irq;
  logic ce = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [7:0] link_status_out;
  lsf_evt_t evt;
  int n_mismatch = 0, samples_checked = 0;
  int n_stop = 0;
  always #10 pclk = ~pclk;
  // counts stop pulses seen on the link side
  always @(negedge pclk) begin
    if (xfer_stop_out === 1'b1) n_stop++;
  end
  lsf_link_model i_link (.pclk(pclk), .evt(evt));
  lsf_status #(.IDLE_CYC(20)) i_dut (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .link_status_out(link_status_out),
    .xfer_stop_out(xfer_stop_out), .irq(irq));
  // ====================
  // bus and compare tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task st(input logic [7:0] e);
    repeat (2) @(negedge pclk);
    chk({24'h0, link_status_out}, {24'h0, e});
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task t_flags;
    apb(1'b0, 12'h024, 8'h00);
    chk(r, 32'h0);
    i_link.hold(11'h600);
    st(8'h80);
    i_link.hold(11'h200);
    st(8'h00);
    apb(1'b1, 12'h020, 8'h01);
    apb(1'b1, 12'h020, 8'h81);
    st(8'h20);
    chk(n_stop, 32'h1);
    i_link.pulse(11'h180);
    st(8'h20);
    i_link.pulse(11'h100);
    st(8'h00);
    i_link.pulse(11'h070);
    st(8'h1C);
    apb(1'b1, 12'h020, 8'h09);
    st(8'h14);
    apb(1'b1, 12'h020, 8'h05);
    st(8'h10);
  endtask
  task t_xfer;
    i_link.pulse(11'h002);
    st(8'h00);
    i_link.pulse(11'h008);
    st(8'h02);
    i_link.pulse(11'h001);
    st(8'h03);
    i_link.pulse(11'h002);
    st(8'h00);
    i_link.pulse(11'h004);
    st(8'h02);
    i_link.pulse(11'h001);
    st(8'h03);
    apb(1'b1, 12'h024, 8'hFF);
    apb(1'b0, 12'h024, 8'h00);
    chk(r, 32'h3);
    apb(1'b0, 12'h030, 8'h00);
    chk({31'h0, se}, 32'h1);
  endtask
  task t_irq;
    apb(1'b0, 12'h028, 8'h00);
    chk(r, 32'hBF);
    apb(1'b1, 12'h02C, 8'h04);
    i_link.pulse(11'h010);
    st(8'h07);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 12'h028, 8'h00);
    chk(r, 32'h4);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task t_idle;
    i_link.hold(11'h000);
    i_link.pulse(11'h400);
    repeat (11) @(negedge pclk);
    st(8'h07);
    repeat (8) @(negedge pclk);
    st(8'h47);
    i_link.pulse(11'h400);
    st(8'h07);
  endtask
  task t_ce;
    @(posedge pclk) ce <= 1'b0;
    i_link.pulse(11'h020);
    st(8'h07);
    @(posedge pclk) ce <= 1'b1;
    i_link.pulse(11'h020);
    st(8'h0F);
  endtask
  task t_rst;
    @(posedge pclk) presetn <= 1'b0;
    @(negedge pclk);
    chk({20'h0, pready, pslverr, irq, xfer_stop_out, link_status_out},
      32'h0);
    chk(prdata, 32'h0);
    @(posedge pclk) presetn <= 1'b1;
    apb(1'b0, 12'h024, 8'h00);
    chk(r, 32'h0);
  endtask
  task wrap_up;
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_flags;
    t_xfer;
    t_irq;
    t_idle;
    t_ce;
    t_rst;
    wrap_up;
  end
  initial begin
    repeat (3000) @(posedge pclk);
    n_mismatch++;
    wrap_up;
  end
endmodule
bind lsf_status lsf_status_sva i_sva (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .evt(evt), .link_status_out(link_status_out));
`default_nettype wire
